// ---- bench/media_model.sv ----
// Sector media model that answers the card's fetch and commit requests
`timescale 1ns/100ps
module media_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic media_req_i,
  input wire logic [27:0] media_lba_i,
  input wire logic [7:0] media_word_i,
  input wire logic [7:0] delay_i,
  input wire logic err_en_i,
  input wire logic [27:0] err_lba_i,
  output logic [15:0] media_rdata_o,
  output logic media_ack_o,
  output logic media_err_o
);
  logic [7:0] wait_r;
  // Word content follows sector address and word index
  assign media_rdata_o = {media_lba_i[7:0] ^ 8'h3C, media_word_i};
  // Failure flag toggles outside the ack, so only the ack cycle carries meaning
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_r <= 8'h00;
      media_ack_o <= 1'b0;
      media_err_o <= 1'b0;
    end else if (media_ack_o) begin
      wait_r <= 8'h00;
      media_ack_o <= 1'b0;
      media_err_o <= ~media_err_o;
    end else if (media_req_i) begin
      wait_r <= wait_r + 8'h01;
      if (wait_r == delay_i) begin
        media_ack_o <= 1'b1;
        media_err_o <= err_en_i && (media_lba_i == err_lba_i);
      end else begin
        media_err_o <= ~media_err_o;
      end
    end else begin
      wait_r <= 8'h00;
      media_err_o <= ~media_err_o;
    end
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking testbench for the task-file command interpreter
`timescale 1ns/100ps
module tb;
  logic sys_clk_i, rstn_i, rd_n, wr_n, ctl, oe, oe_q, irq, req, wstb, ack, merr, slv, err_en;
  logic mwr, exp_wr;
  logic [2:0] addr;
  logic [3:0] dfail;
  logic [7:0] word, delay;
  logic [15:0] din, dout, rdata, wdata, r, d;
  logic [27:0] lba_o, err_lba, l, l2;
  logic [31:0] eq[$];
  logic [15:0] wq[$];
  int n_errors, check_count;

  ata_task_file #(.drq_wr_cyc(1000)) ata_task_file_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .io_read_strobe_n_i(rd_n),
    .io_write_strobe_n_i(wr_n), .ctl_sel_i(ctl), .io_addr_i(addr), .data_i(din),
    .data_o(dout), .data_oe_o(oe), .card_interrupt_line_o(irq), .media_req_o(req),
    .media_write_o(mwr), .media_lba_o(lba_o), .media_word_o(word), .media_rdata_i(rdata),
    .media_wdata_o(wdata), .media_wstb_o(wstb), .media_ack_i(ack), .media_err_i(merr),
    .diag_unit_fail_i(dfail), .slave_fail_i(slv));

  media_model media_model_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .media_req_i(req), .media_lba_i(lba_o),
    .media_word_i(word), .delay_i(delay), .err_en_i(err_en), .err_lba_i(err_lba),
    .media_rdata_o(rdata), .media_ack_o(ack), .media_err_o(merr));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic fail(input logic [15:0] got, exp);
    n_errors++;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask

  task automatic cmp(input logic [15:0] got, exp, m);
    check_count++;
    if ((got & m) !== (exp & m)) fail(got, exp);
  endtask

  // Results appear when the read enable drops; compare with the oldest note
  always @(posedge sys_clk_i) begin
    oe_q <= oe;
    if (oe_q && !oe && eq.size() > 0) begin
      if (eq[0][31:16] != 16'h0000) cmp(dout, eq[0][15:0], eq[0][31:16]);
      void'(eq.pop_front());
    end
    if (wstb === 1'b1 && wq.size() > 0) cmp(wdata, wq.pop_front(), 16'hFFFF);
    if (req === 1'b1 && ack === 1'b1) cmp({15'h0000, mwr}, {15'h0000, exp_wr}, 16'h0001);
  end

  task automatic rd(input logic c, input logic [2:0] a, input logic [15:0] m, v);
    @(posedge sys_clk_i);
    ctl <= c;
    addr <= a;
    rd_n <= 1'b0;
    eq.push_back({m, v});
    repeat (4) @(posedge sys_clk_i);
    rd_n <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    r = dout;
  endtask

  task automatic wr(input logic c, input logic [2:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    ctl <= c;
    addr <= a;
    din <= v;
    wr_n <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    wr_n <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask

  // Alternate status polling leaves a pending interrupt alone
  task automatic poll(input logic [7:0] m, v);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(1'b1, 3'h6, 16'h0000, 16'h0000);
      if ((r[7:0] & m) === v) break;
    end
    if (i == 3000) fail(r, {8'h00, v});
  endtask

  task automatic ld(input logic [27:0] a, input logic [7:0] n);
    wr(1'b0, 3'h2, {8'h00, n});
    wr(1'b0, 3'h3, {8'h00, a[7:0]});
    wr(1'b0, 3'h4, {8'h00, a[15:8]});
    wr(1'b0, 3'h5, {8'h00, a[23:16]});
    wr(1'b0, 3'h6, {12'h00E, a[27:24]});
  endtask

  // Mode 0 words, 1 bytes low first, 2 identify words
  task automatic sect_rd(input logic [27:0] a, input logic [1:0] md);
    poll(8'h88, 8'h08);
    for (int w = 0; w < 256; w++) begin
      if (md == 2'h1) begin
        rd(1'b0, 3'h0, 16'h00FF, {8'h00, w[7:0]});
        rd(1'b0, 3'h0, 16'h00FF, {8'h00, a[7:0] ^ 8'h3C});
      end else if (md == 2'h2) begin
        rd(1'b0, 3'h0, 16'hFFFF, (w == 0) ? ata_pkg::ID_WORD0 : 16'h0000);
      end else begin
        rd(1'b0, 3'h0, 16'hFFFF, {a[7:0] ^ 8'h3C, w[7:0]});
      end
    end
  endtask

  // Byte mode sends low byte first; one strobe per completed word
  task automatic sect_wr(input logic bm);
    poll(8'h88, 8'h08);
    repeat (256) begin
      d = 16'($urandom);
      wq.push_back(d);
      if (bm) begin
        wr(1'b0, 3'h0, {8'h00, d[7:0]});
        wr(1'b0, 3'h0, {8'h00, d[15:8]});
      end else begin
        wr(1'b0, 3'h0, d);
      end
    end
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    test_done();
  end

  initial begin
    logic [7:0] e;
    rstn_i = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ctl = 1'b0;
    addr = 3'h0;
    din = 16'h0000;
    dfail = 4'h0;
    slv = 1'b0;
    delay = 8'h28;
    err_en = 1'b0;
    err_lba = 28'h0000000;
    exp_wr = 1'b0;
    void'($urandom(32'h5812));
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rd(1'b0, 3'h7, 16'h00FF, 16'h0050);
    rd(1'b0, 3'h2, 16'h00FF, {8'h00, ata_pkg::SCNT_RST});
    wr(1'b1, 3'h6, 16'h0002);
    for (int i = 0; i < 6; i++) begin
      dfail <= (i < 4) ? 4'(($urandom << (i + 1)) | (1 << i)) : 4'h0;
      slv <= (i == 5);
      e = (i < 4) ? 8'(2 + i) : ((i == 5) ? 8'h81 : 8'h01);
      wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_DIAG});
      poll(8'hC0, 8'h40);
      rd(1'b0, 3'h1, 16'h00FF, {8'h00, e});
    end
    wr(1'b0, 3'h7, 16'h00FF);
    poll(8'hC0, 8'h40);
    rd(1'b0, 3'h1, 16'h00FF, {8'h00, ata_pkg::ERR_ABORT});
    l = 28'($urandom);
    l2 = l + 28'h1;
    ld(l, 8'h02);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_READ});
    rd(1'b1, 3'h6, 16'h0088, 16'h0080);
    wr(1'b0, 3'h3, {8'h00, ~l[7:0]});
    sect_rd(l, 2'h0);
    sect_rd(l2, 2'h0);
    poll(8'hC0, 8'h40);
    cmp({15'h0000, irq}, 16'h0000, 16'hFFFF);
    rd(1'b0, 3'h2, 16'h00FF, 16'h0000);
    rd(1'b0, 3'h3, 16'h00FF, {8'h00, l2[7:0]});
    rd(1'b0, 3'h4, 16'h00FF, {8'h00, l2[15:8]});
    l = 28'($urandom);
    l2 = l + 28'h1;
    err_lba <= l2;
    err_en <= 1'b1;
    ld(l, 8'h03);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_READ});
    sect_rd(l, 2'h0);
    poll(8'hC0, 8'h40);
    rd(1'b1, 3'h6, 16'h00C9, 16'h0041);
    rd(1'b0, 3'h1, 16'h00FF, {8'h00, ata_pkg::ERR_MEDIA});
    rd(1'b0, 3'h3, 16'h00FF, {8'h00, l2[7:0]});
    rd(1'b0, 3'h2, 16'h00FF, 16'h0002);
    err_en <= 1'b0;
    delay <= 8'h02;
    l = 28'($urandom);
    l2 = l + 28'h1;
    ld(l, 8'h02);
    exp_wr = 1'b1;
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_WRITE});
    sect_wr(1'b0);
    sect_wr(1'b0);
    poll(8'hC0, 8'h40);
    rd(1'b0, 3'h2, 16'h00FF, 16'h0000);
    rd(1'b0, 3'h3, 16'h00FF, {8'h00, l2[7:0]});
    err_lba <= l;
    err_en <= 1'b1;
    ld(l, 8'h02);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_WRITE});
    sect_wr(1'b0);
    poll(8'hC0, 8'h40);
    rd(1'b1, 3'h6, 16'h00E9, 16'h0061);
    rd(1'b0, 3'h3, 16'h00FF, {8'h00, l[7:0]});
    err_en <= 1'b0;
    exp_wr = 1'b0;
    ld(l, 8'h00);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_READ});
    sect_rd(l, 2'h0);
    poll(8'h88, 8'h08);
    rd(1'b0, 3'h2, 16'h00FF, 16'h00FF);
    wr(1'b1, 3'h6, 16'h0006);
    wr(1'b1, 3'h6, 16'h0000);
    poll(8'hC0, 8'h40);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_IDENT});
    poll(8'h88, 8'h08);
    cmp({15'h0000, irq}, 16'h0001, 16'hFFFF);
    rd(1'b0, 3'h7, 16'h0088, 16'h0008);
    cmp({15'h0000, irq}, 16'h0000, 16'hFFFF);
    sect_rd(l, 2'h2);
    poll(8'hC0, 8'h40);
    wr(1'b1, 3'h6, 16'h0002);
    wr(1'b0, 3'h1, {8'h00, ata_pkg::FEAT_8BIT});
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_FEAT});
    poll(8'hC0, 8'h40);
    l = 28'($urandom);
    ld(l, 8'h01);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_READ});
    sect_rd(l, 2'h1);
    poll(8'hC0, 8'h40);
    exp_wr = 1'b1;
    ld(l, 8'h01);
    wr(1'b0, 3'h7, {8'h00, ata_pkg::CMD_WRITE});
    sect_wr(1'b1);
    poll(8'hC0, 8'h40);
    rd(1'b0, 3'h2, 16'h00FF, 16'h0000);
    poll(8'hC0, 8'h40);
    cmp(16'(wq.size()), 16'h0000, 16'hFFFF);
    test_done();
  end
endmodule

// ---- core/ata_pkg.sv ----
// Constants for the task-file command interpreter
package ata_pkg;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ERR_FEAT = 3'h1;
  localparam logic [2:0] REG_SCNT = 3'h2;
  localparam logic [2:0] REG_SNUM = 3'h3;
  localparam logic [2:0] REG_CYLL = 3'h4;
  localparam logic [2:0] REG_CYLH = 3'h5;
  localparam logic [2:0] REG_HEAD = 3'h6;
  localparam logic [2:0] REG_STAT_CMD = 3'h7;
  localparam logic [2:0] REG_ALT_CTL = 3'h6;
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_WRITE = 8'h30;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_IDENT = 8'hEC;
  localparam logic [7:0] CMD_FEAT = 8'hEF;
  localparam logic [7:0] FEAT_8BIT = 8'h01;
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_FMT = 8'h02;
  localparam logic [7:0] DIAG_BUF = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [7:0] DIAG_SLAVE = 8'h80;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_MEDIA = 8'h40;
  localparam int DC_NIEN = 1;
  localparam int DC_SRST = 2;
  localparam int HEAD_LBA = 6;
  localparam logic [7:0] SCNT_RST = 8'h01;
  localparam logic [7:0] SNUM_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [9:0] WORD_LAST = 10'h0FF;
  localparam logic [9:0] BYTE_LAST = 10'h1FF;
  localparam logic [8:0] SECT_MAX = 9'h100;
  // Arbitrary value for the first identify word
  localparam logic [15:0] ID_WORD0 = 16'h0A5A;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BUSY_SET_NS = 400;
  localparam int BUSY_SET_CYC = (BUSY_SET_NS * 1000) / CLK_PERIOD_PS;
  localparam int DRQ_WR_US = 700;
  localparam int DRQ_WR_CYC = (DRQ_WR_US * 1000 * 1000) / CLK_PERIOD_PS;
endpackage

// ---- core/ata_task_file.sv ----
// Task-file register set and command interpreter of the card
`timescale 1ns/100ps
module ata_task_file #(
  parameter int unsigned drq_wr_cyc = ata_pkg::DRQ_WR_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic io_read_strobe_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic ctl_sel_i,
  input wire logic [2:0] io_addr_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic card_interrupt_line_o,
  output logic media_req_o,
  output logic media_write_o,
  output logic [27:0] media_lba_o,
  output logic [7:0] media_word_o,
  input wire logic [15:0] media_rdata_i,
  output logic [15:0] media_wdata_o,
  output logic media_wstb_o,
  input wire logic media_ack_i,
  input wire logic media_err_i,
  input wire logic [3:0] diag_unit_fail_i,
  input wire logic slave_fail_i
);
  typedef enum logic [2:0] {S_IDLE, S_EXEC, S_FETCH, S_XIN, S_XOUT, S_COMMIT} state_e;
  state_e state_r;
  logic rd_pulse, wr_pulse;
  logic [7:0] feat_r, scnt_r, snum_r, cyll_r, cylh_r, head_r, err_r, cmd_r, lo_r;
  logic busy_r, rdy_r, drq_r, errf_r, dwf_r, byte_mode_r, nien_r, srst_r, busy_d_r;
  logic [8:0] remain_r;
  logic [9:0] wcnt_r, wcnt_inc, last;
  logic [27:0] lba, lba_inc;
  logic [7:0] status, diag_code;
  logic tf_wr, tf_rd, cmd_wr, data_rd, data_wr, sect_done, more, word_done;

  strobe_fall u_rd (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .strobe_n_i(io_read_strobe_n_i),
    .fall_o(rd_pulse)
  );
  strobe_fall u_wr (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .strobe_n_i(io_write_strobe_n_i),
    .fall_o(wr_pulse)
  );

  // Access decode; a strobe pair with both low is ignored except for device control writes
  assign tf_wr = wr_pulse && io_read_strobe_n_i && !ctl_sel_i;
  assign tf_rd = rd_pulse && io_write_strobe_n_i && !ctl_sel_i;
  assign cmd_wr = tf_wr && io_addr_i == ata_pkg::REG_STAT_CMD && state_r == S_IDLE;
  assign data_rd = tf_rd && io_addr_i == ata_pkg::REG_DATA && state_r == S_XIN;
  assign data_wr = tf_wr && io_addr_i == ata_pkg::REG_DATA && state_r == S_XOUT;
  assign status = {busy_r, rdy_r, dwf_r, rdy_r, drq_r, 1'b0, 1'b0, errf_r};
  assign last = byte_mode_r ? ata_pkg::BYTE_LAST : ata_pkg::WORD_LAST;
  assign wcnt_inc = wcnt_r + 10'h001;
  assign word_done = !byte_mode_r || wcnt_r[0];
  assign lba = {head_r[3:0], cylh_r, cyll_r, snum_r};
  assign lba_inc = lba + 28'h0000001;
  assign more = remain_r != 9'h001;
  assign sect_done = (data_rd && wcnt_r == last && cmd_r == ata_pkg::CMD_READ) ||
                     (state_r == S_COMMIT && media_ack_i && !media_err_i);

  always_comb begin
    diag_code = ata_pkg::DIAG_OK;
    if (diag_unit_fail_i[0]) diag_code = ata_pkg::DIAG_FMT;
    else if (diag_unit_fail_i[1]) diag_code = ata_pkg::DIAG_BUF;
    else if (diag_unit_fail_i[2]) diag_code = ata_pkg::DIAG_ECC;
    else if (diag_unit_fail_i[3]) diag_code = ata_pkg::DIAG_CPU;
    if (slave_fail_i) diag_code = diag_code | ata_pkg::DIAG_SLAVE;
  end

  // Command sequencing
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
      rdy_r <= 1'b1;
      drq_r <= 1'b0;
      errf_r <= 1'b0;
      dwf_r <= 1'b0;
      err_r <= ata_pkg::DIAG_OK;
      cmd_r <= ata_pkg::ZERO_RST;
      byte_mode_r <= 1'b0;
      remain_r <= 9'h000;
      wcnt_r <= 10'h000;
      media_req_o <= 1'b0;
      media_write_o <= 1'b0;
      media_word_o <= 8'h00;
      media_wdata_o <= 16'h0000;
      media_wstb_o <= 1'b0;
      lo_r <= 8'h00;
    end else if (srst_r) begin
      state_r <= S_IDLE;
      busy_r <= 1'b0;
      rdy_r <= 1'b1;
      drq_r <= 1'b0;
      errf_r <= 1'b0;
      media_req_o <= 1'b0;
      media_wstb_o <= 1'b0;
    end else begin
      media_wstb_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_wr) begin
            busy_r <= 1'b1;
            rdy_r <= 1'b0;
            errf_r <= 1'b0;
            dwf_r <= 1'b0;
            cmd_r <= data_i[7:0];
            remain_r <= (scnt_r == 8'h00) ? ata_pkg::SECT_MAX : {1'b0, scnt_r};
            wcnt_r <= 10'h000;
            media_word_o <= 8'h00;
            if (data_i[7:0] == ata_pkg::CMD_READ) begin
              state_r <= S_FETCH;
              media_req_o <= 1'b1;
              media_write_o <= 1'b0;
            end else begin
              state_r <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          busy_r <= 1'b0;
          case (cmd_r)
            ata_pkg::CMD_WRITE: begin
              drq_r <= 1'b1;
              state_r <= S_XOUT;
            end
            ata_pkg::CMD_IDENT: begin
              drq_r <= 1'b1;
              state_r <= S_XIN;
            end
            ata_pkg::CMD_DIAG: begin
              err_r <= diag_code;
              rdy_r <= 1'b1;
              state_r <= S_IDLE;
            end
            ata_pkg::CMD_FEAT: begin
              if (feat_r == ata_pkg::FEAT_8BIT) byte_mode_r <= 1'b1;
              rdy_r <= 1'b1;
              state_r <= S_IDLE;
            end
            default: begin
              err_r <= ata_pkg::ERR_ABORT;
              errf_r <= 1'b1;
              rdy_r <= 1'b1;
              state_r <= S_IDLE;
            end
          endcase
        end
        S_FETCH: begin
          if (media_ack_i) begin
            media_req_o <= 1'b0;
            busy_r <= 1'b0;
            if (media_err_i) begin
              err_r <= ata_pkg::ERR_MEDIA;
              errf_r <= 1'b1;
              rdy_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              drq_r <= 1'b1;
              state_r <= S_XIN;
            end
          end
        end
        S_XIN: begin
          if (data_rd) begin
            wcnt_r <= (wcnt_r == last) ? 10'h000 : wcnt_inc;
            media_word_o <= byte_mode_r ? wcnt_inc[8:1] : wcnt_inc[7:0];
            if (wcnt_r == last) begin
              drq_r <= 1'b0;
              media_word_o <= 8'h00;
              if (cmd_r == ata_pkg::CMD_READ && more) begin
                remain_r <= remain_r - 9'h001;
                busy_r <= 1'b1;
                media_req_o <= 1'b1;
                state_r <= S_FETCH;
              end else begin
                rdy_r <= 1'b1;
                state_r <= S_IDLE;
              end
            end
          end
        end
        S_XOUT: begin
          if (data_wr) begin
            wcnt_r <= (wcnt_r == last) ? 10'h000 : wcnt_inc;
            media_word_o <= byte_mode_r ? wcnt_r[8:1] : wcnt_r[7:0];
            lo_r <= data_i[7:0];
            media_wstb_o <= word_done;
            media_wdata_o <= byte_mode_r ? {data_i[7:0], lo_r} : data_i;
            if (wcnt_r == last) begin
              drq_r <= 1'b0;
              busy_r <= 1'b1;
              media_req_o <= 1'b1;
              media_write_o <= 1'b1;
              state_r <= S_COMMIT;
            end
          end
        end
        S_COMMIT: begin
          if (media_ack_i) begin
            media_req_o <= 1'b0;
            busy_r <= 1'b0;
            media_word_o <= 8'h00;
            if (media_err_i) begin
              err_r <= ata_pkg::ERR_MEDIA;
              errf_r <= 1'b1;
              dwf_r <= 1'b1;
              rdy_r <= 1'b1;
              state_r <= S_IDLE;
            end else if (more) begin
              remain_r <= remain_r - 9'h001;
              drq_r <= 1'b1;
              state_r <= S_XOUT;
            end else begin
              rdy_r <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Parameter registers, host writes and per-sector address advance
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      feat_r <= ata_pkg::ZERO_RST;
      scnt_r <= ata_pkg::SCNT_RST;
      snum_r <= ata_pkg::SNUM_RST;
      cyll_r <= ata_pkg::ZERO_RST;
      cylh_r <= ata_pkg::ZERO_RST;
      head_r <= ata_pkg::ZERO_RST;
      media_lba_o <= 28'h0000000;
    end else begin
      media_lba_o <= (sect_done && more) ? lba_inc : lba;
      if (tf_wr && state_r == S_IDLE) begin
        case (io_addr_i)
          ata_pkg::REG_ERR_FEAT: feat_r <= data_i[7:0];
          ata_pkg::REG_SCNT: scnt_r <= data_i[7:0];
          ata_pkg::REG_SNUM: snum_r <= data_i[7:0];
          ata_pkg::REG_CYLL: cyll_r <= data_i[7:0];
          ata_pkg::REG_CYLH: cylh_r <= data_i[7:0];
          ata_pkg::REG_HEAD: head_r <= data_i[7:0];
          default: ;
        endcase
      end else if (sect_done) begin
        scnt_r <= scnt_r - 8'h01;
        if (more) {head_r[3:0], cylh_r, cyll_r, snum_r} <= lba_inc;
      end
    end
  end

  // Device control register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nien_r <= 1'b0;
      srst_r <= 1'b0;
    end else if (wr_pulse && ctl_sel_i && io_addr_i == ata_pkg::REG_ALT_CTL) begin
      nien_r <= data_i[ata_pkg::DC_NIEN];
      srst_r <= data_i[ata_pkg::DC_SRST];
    end
  end

  // Interrupt raised when busy drops; set wins over the status-read clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_d_r <= 1'b0;
      card_interrupt_line_o <= 1'b0;
    end else begin
      busy_d_r <= busy_r;
      if (busy_d_r && !busy_r && !nien_r) card_interrupt_line_o <= 1'b1;
      else if (tf_rd && io_addr_i == ata_pkg::REG_STAT_CMD) card_interrupt_line_o <= 1'b0;
      else if (nien_r) card_interrupt_line_o <= 1'b0;
    end
  end

  // Read data path
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= 16'h0000;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= !io_read_strobe_n_i && io_write_strobe_n_i;
      if (rd_pulse && ctl_sel_i) begin
        data_o <= (io_addr_i == ata_pkg::REG_ALT_CTL) ? {8'h00, status} : 16'h0000;
      end else if (tf_rd) begin
        case (io_addr_i)
          ata_pkg::REG_DATA: begin
            if (state_r != S_XIN) data_o <= 16'h0000;
            else if (cmd_r == ata_pkg::CMD_IDENT)
              data_o <= (media_word_o == 8'h00) ? ata_pkg::ID_WORD0 : 16'h0000;
            else if (byte_mode_r)
              data_o <= {8'h00, wcnt_r[0] ? media_rdata_i[15:8] : media_rdata_i[7:0]};
            else data_o <= media_rdata_i;
          end
          ata_pkg::REG_ERR_FEAT: data_o <= {8'h00, err_r};
          ata_pkg::REG_SCNT: data_o <= {8'h00, scnt_r};
          ata_pkg::REG_SNUM: data_o <= {8'h00, snum_r};
          ata_pkg::REG_CYLL: data_o <= {8'h00, cyll_r};
          ata_pkg::REG_CYLH: data_o <= {8'h00, cylh_r};
          ata_pkg::REG_HEAD: data_o <= {8'h00, head_r};
          default: data_o <= {8'h00, status};
        endcase
      end
    end
  end

  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i || srst_r);
  localparam int bmax = ata_pkg::BUSY_SET_CYC;
  logic [17:0] drq_wait_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) drq_wait_r <= 18'h00000;
    else if (cmd_wr && data_i[7:0] == ata_pkg::CMD_WRITE) drq_wait_r <= 18'h00001;
    else if (drq_r || state_r == S_IDLE) drq_wait_r <= 18'h00000;
    else if (drq_wait_r != 18'h00000) drq_wait_r <= drq_wait_r + 18'h00001;
  end

  busy_on_cmd_a: assert property (cmd_wr |-> ##[1:bmax] busy_r)
    else $error("busy not set after command");
  wr_drq_time_a: assert property (drq_wait_r < 18'(drq_wr_cyc))
    else $error("write data request late");
  wr_busy_drop_a: assert property ($rose(drq_r) |-> !busy_r ##1 !busy_r)
    else $error("busy kept with data request");
  ready_idle_a: assert property (state_r == S_IDLE && !$past(cmd_wr) |-> rdy_r && !busy_r)
    else $error("idle without ready");
  count_zero_a: assert property (cmd_wr && scnt_r == 8'h00 |=> remain_r == 9'h100)
    else $error("zero count not 256");
  feat_byte_a: assert property (cmd_wr && data_i[7:0] == ata_pkg::CMD_FEAT &&
    feat_r == ata_pkg::FEAT_8BIT |-> ##2 byte_mode_r)
    else $error("8-bit mode not taken");
  diag_code_a: assert property (cmd_wr && data_i[7:0] == ata_pkg::CMD_DIAG &&
    diag_unit_fail_i == 4'h0 && !slave_fail_i |-> ##2 err_r == ata_pkg::DIAG_OK)
    else $error("diagnostic code wrong");
  media_err_a: assert property ((state_r == S_FETCH || state_r == S_COMMIT) && media_ack_i &&
    media_err_i |=> state_r == S_IDLE && errf_r && $stable(lba))
    else $error("error did not stop transfer");
  busy_lock_a: assert property (busy_r && tf_wr |=> $stable(snum_r) && $stable(scnt_r))
    else $error("register written while busy");
  irq_clear_a: assert property (tf_rd && io_addr_i == ata_pkg::REG_STAT_CMD &&
    !(busy_d_r && !busy_r) |=> !card_interrupt_line_o)
    else $error("status read kept interrupt");
  alt_keep_a: assert property (rd_pulse && ctl_sel_i && card_interrupt_line_o && !nien_r
    |=> card_interrupt_line_o)
    else $error("alternate read cleared interrupt");

  read_done_c: cover property (state_r == S_XIN && cmd_r == ata_pkg::CMD_READ
    ##1 state_r == S_IDLE);
  write_done_c: cover property (state_r == S_COMMIT && media_ack_i && !media_err_i && !more);
  ident_c: cover property (state_r == S_XIN && cmd_r == ata_pkg::CMD_IDENT && data_rd);
  error_c: cover property (media_ack_i && media_err_i);
endmodule

// ---- core/strobe_fall.sv ----
// Falling-edge detector for an active-low host strobe
`timescale 1ns/100ps
module strobe_fall (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic strobe_n_i,
  output logic fall_o
);
  logic prev_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= strobe_n_i;
    end
  end
  assign fall_o = prev_r && !strobe_n_i;
endmodule
